/* File: hw/rrso_alu.sv */
// rrso_alu: combinational result of one operation from accumulator, memory byte and flags
// assumes: inputs stable within the cycle; caller registers the result
`timescale 1ns/100ps
`default_nettype none
module rrso_alu (
   // operands
   input wire rrso_pkg::rrso_req_t req,
   input wire logic [rrso_pkg::DATA_W-1:0] acc,
   input wire rrso_pkg::rrso_flags_t flags,
   // result
   output rrso_pkg::rrso_res_t res
);

   logic [rrso_pkg::DATA_W:0] diff9;
   logic [rrso_pkg::NIB_W:0] diff5;
   logic [rrso_pkg::DATA_W-1:0] m;
   logic borrow_in;
   logic wrap;
   logic zero;

   always_comb begin
      m = req.mem_byte;
      borrow_in = ~flags.carry_flag;
      diff9 = {1'b0, acc} - {1'b0, m} - {{rrso_pkg::DATA_W{1'b0}}, borrow_in};
      diff5 = {1'b0, acc[rrso_pkg::NIB_W-1:0]} - {1'b0, m[rrso_pkg::NIB_W-1:0]}
            - {{rrso_pkg::NIB_W{1'b0}}, borrow_in};
      wrap = (acc[rrso_pkg::MSB] != m[rrso_pkg::MSB]) && (diff9[rrso_pkg::MSB] != acc[rrso_pkg::MSB]);
      zero = (diff9[rrso_pkg::DATA_W-1:0] == 8'h00);
      res.acc_we = 1'b0;
      res.acc = acc;
      res.mem_we = 1'b0;
      res.mem = m;
      res.flags = flags;
      case (req.op)
         rrso_pkg::rrso_op_rotate_right_mem: begin
            res.mem = {m[0], m[rrso_pkg::MSB:1]};
            res.mem_we = 1'b1;
         end
         rrso_pkg::rrso_op_rotate_right_to_acc: begin
            res.acc = {m[0], m[rrso_pkg::MSB:1]};
            res.acc_we = 1'b1;
         end
         rrso_pkg::rrso_op_rotate_right_thru_carry_mem: begin
            res.mem = {flags.carry_flag, m[rrso_pkg::MSB:1]};
            res.mem_we = 1'b1;
            res.flags.carry_flag = m[0];
         end
         rrso_pkg::rrso_op_rotate_right_thru_carry_to_acc: begin
            res.acc = {flags.carry_flag, m[rrso_pkg::MSB:1]};
            res.acc_we = 1'b1;
            res.flags.carry_flag = m[0];
         end
         rrso_pkg::rrso_op_subtract_borrow_to_acc,
         rrso_pkg::rrso_op_subtract_borrow_to_mem: begin
            if (req.op == rrso_pkg::rrso_op_subtract_borrow_to_acc) begin
               res.acc = diff9[rrso_pkg::DATA_W-1:0];
               res.acc_we = 1'b1;
            end else begin
               res.mem = diff9[rrso_pkg::DATA_W-1:0];
               res.mem_we = 1'b1;
            end
            // borrow out means negative: carry clears
            res.flags.carry_flag = ~diff9[rrso_pkg::DATA_W];
            res.flags.twos_complement_wrap_flag = wrap;
            res.flags.zero_flag = zero;
            res.flags.half_carry_flag = ~diff5[rrso_pkg::NIB_W];
            res.flags.signed_compare_flag = wrap ^ diff9[rrso_pkg::MSB];
            // chained zero lets multi-byte subtracts test the whole result
            res.flags.chained_zero_flag = zero & flags.chained_zero_flag;
         end
         default: begin
            res.acc_we = 1'b0;
         end
      endcase
   end

endmodule
`default_nettype wire

/* File: hw/rrso_pkg.sv */
// rrso_pkg: operation codes, flag layout and carriers for the rotate-right / subtract-with-borrow datapath
// assumes: single core clock domain, all users reference names as rrso_pkg::name
package rrso_pkg;

   localparam int unsigned DATA_W = 8;
   localparam int unsigned NIB_W = 4;
   localparam int unsigned MSB = DATA_W - 1;

   typedef enum logic [2:0] {
      rrso_op_rotate_right_mem,
      rrso_op_rotate_right_to_acc,
      rrso_op_rotate_right_thru_carry_mem,
      rrso_op_rotate_right_thru_carry_to_acc,
      rrso_op_subtract_borrow_to_acc,
      rrso_op_subtract_borrow_to_mem
   } rrso_op_t;

   // status flags, msb first: wrap, zero, half carry, carry, signed compare, chained zero
   typedef struct packed {
      logic twos_complement_wrap_flag;
      logic zero_flag;
      logic half_carry_flag;
      logic carry_flag;
      logic signed_compare_flag;
      logic chained_zero_flag;
   } rrso_flags_t;

   localparam int unsigned FLAGS_W = 6;
   localparam rrso_flags_t FLAGS_RST = 6'h00;
   localparam logic [DATA_W-1:0] ACC_RST = 8'h00;

   typedef struct packed {
      rrso_op_t op;
      logic [DATA_W-1:0] mem_byte;
   } rrso_req_t;

   typedef struct packed {
      logic acc_we;
      logic [DATA_W-1:0] acc;
      logic mem_we;
      logic [DATA_W-1:0] mem;
      rrso_flags_t flags;
   } rrso_res_t;

endpackage

/* File: hw/rrso_top.sv */
// rrso_top: accumulator, status flags and memory write-back for the right rotates and subtracts with borrow
// assumes: decoder presents one operation per cycle with the addressed memory byte already read;
// memory takes mem_we/mem_wdata one cycle after the request
//
// Functional notes
// - rotate_right_mem rotates the memory byte right with bit 0 into bit 7, writes it back, keeps all flags.
// - rotate_right_to_acc puts the right-rotated byte in the accumulator, leaves memory and flags alone.
// - rotate_right_thru_carry_mem rotates through carry: carry into bit 7, bit 0 into carry, byte to memory.
// - rotate_right_thru_carry_to_acc does the same ring rotate but the byte goes to the accumulator.
// - subtract_borrow_to_acc writes accumulator minus memory minus inverted carry to the accumulator.
// - subtract_borrow_to_mem writes the same difference to the addressed memory byte.
// - both subtracts clear carry on a negative difference and set it when zero or positive.
// - both subtracts update wrap, zero, half carry, carry, signed compare and chained zero flags.
`timescale 1ns/100ps
`default_nettype none
module rrso_top (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // operation request
   input wire logic op_valid,
   input wire rrso_pkg::rrso_req_t op_req,
   // loads from the rest of the core
   input wire logic acc_load,
   input wire logic [rrso_pkg::DATA_W-1:0] acc_load_data,
   input wire logic flags_load,
   input wire rrso_pkg::rrso_flags_t flags_load_data,
   // memory write-back
   output logic mem_we,
   output logic [rrso_pkg::DATA_W-1:0] mem_wdata,
   // architectural state
   output logic [rrso_pkg::DATA_W-1:0] acc,
   output rrso_pkg::rrso_flags_t flags
);

   ////////////////////////////////////////////////////////////////////////////
   // reset release

   logic [1:0] rst_sync_r;
   logic rst_n;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_r[1];

   ////////////////////////////////////////////////////////////////////////////
   // operation result

   // state is declared ahead of the datapath that reads it
   logic [rrso_pkg::DATA_W-1:0] acc_r;
   logic [rrso_pkg::DATA_W-1:0] acc_nxt;
   rrso_pkg::rrso_flags_t flags_r;
   rrso_pkg::rrso_flags_t flags_nxt;
   logic mem_we_r;
   logic mem_we_nxt;
   logic [rrso_pkg::DATA_W-1:0] mem_wdata_r;
   logic [rrso_pkg::DATA_W-1:0] mem_wdata_nxt;
   rrso_pkg::rrso_res_t alu_res;

   rrso_alu u_alu (
      .req(op_req),
      .acc(acc_r),
      .flags(flags_r),
      .res(alu_res)
   );

   ////////////////////////////////////////////////////////////////////////////
   // state update

   // an operation outranks a same-cycle load so its flags are never lost
   always_comb begin
      acc_nxt = acc_r;
      flags_nxt = flags_r;
      mem_we_nxt = 1'b0;
      mem_wdata_nxt = mem_wdata_r;
      if (op_valid) begin
         if (alu_res.acc_we) begin
            acc_nxt = alu_res.acc;
         end
         // memory-target ops keep the accumulator as is
         flags_nxt = alu_res.flags;
         mem_we_nxt = alu_res.mem_we;
         if (alu_res.mem_we) begin
            mem_wdata_nxt = alu_res.mem;
         end
      end else begin
         if (acc_load) begin
            acc_nxt = acc_load_data;
         end
         if (flags_load) begin
            flags_nxt = flags_load_data;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_r <= rrso_pkg::ACC_RST;
         flags_r <= rrso_pkg::FLAGS_RST;
         mem_we_r <= 1'b0;
         mem_wdata_r <= 8'h00;
      end else begin
         acc_r <= acc_nxt;
         flags_r <= flags_nxt;
         mem_we_r <= mem_we_nxt;
         mem_wdata_r <= mem_wdata_nxt;
      end
   end

   assign acc = acc_r;
   assign flags = flags_r;
   assign mem_we = mem_we_r;
   assign mem_wdata = mem_wdata_r;

endmodule
`default_nettype wire

/* File: tb/rrso_top_chk.sv */
// rrso_top_chk: port assertions for rrso_top
// assumes: bound to rrso_top, single core clock
`timescale 1ns/100ps
`default_nettype none
module rrso_top_chk (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // request
   input wire logic op_valid,
   input wire rrso_pkg::rrso_req_t op_req,
   // results
   input wire logic mem_we,
   input wire logic [7:0] mem_wdata,
   input wire logic [7:0] acc,
   input wire rrso_pkg::rrso_flags_t flags
);
   logic [1:0] rdy_r, rdy_nxt;
   logic [8:0] d;
   logic [4:0] h;
   logic [7:0] m, rot, rtc;
   logic [2:0] o;
   logic ok, sb, w;
   // ops before the internal reset copy lets go are ignored
   always_comb begin
      rdy_nxt = {rdy_r[0], 1'b1};
   end
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rdy_r <= 2'h0;
      end else begin
         rdy_r <= rdy_nxt;
      end
   end
   assign o = op_req.op;
   assign m = op_req.mem_byte;
   assign rot = {m[0], m[7:1]};
   assign rtc = {flags.carry_flag, m[7:1]};
   assign d = {1'b0, acc} - {1'b0, m} - {8'h00, !flags.carry_flag};
   assign h = {1'b0, acc[3:0]} - {1'b0, m[3:0]} - {4'h0, !flags.carry_flag};
   assign w = (acc[7] != m[7]) && (d[7] != acc[7]);
   assign ok = op_valid && rdy_r[1];
   assign sb = ok && (o == 3'h4 || o == 3'h5);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   AST_RR_MEM: assert property (ok && o == 3'h0 |=>
      mem_we && mem_wdata == $past(rot) && $stable(flags) && $stable(acc)) else $error("rotate to memory");
   AST_RR_ACC: assert property (ok && o == 3'h1 |=>
      !mem_we && acc == $past(rot) && $stable(flags)) else $error("rotate to acc");
   AST_RRC_MEM: assert property (ok && o == 3'h2 |=>
      mem_we && mem_wdata == $past(rtc) && flags.carry_flag == $past(rot[7])) else $error("ring to memory");
   AST_RRC_ACC: assert property (ok && o == 3'h3 |=>
      !mem_we && acc == $past(rtc) && flags.carry_flag == $past(rot[7])) else $error("ring to acc");
   AST_SB_ACC: assert property (ok && o == 3'h4 |=>
      !mem_we && acc == $past(d[7:0])) else $error("subtract to acc");
   AST_SB_MEM: assert property (ok && o == 3'h5 |=>
      mem_we && mem_wdata == $past(d[7:0]) && $stable(acc)) else $error("subtract to memory");
   AST_SB_C: assert property (sb |=> flags.carry_flag != $past(d[8])) else $error("borrow carry");
   AST_SB_FLG: assert property (sb |=> flags.zero_flag == ($past(d[7:0]) == 8'h00) &&
      flags.half_carry_flag != $past(h[4]) && flags.twos_complement_wrap_flag == $past(w) &&
      flags.signed_compare_flag == ($past(w) ^ $past(d[7]))) else $error("subtract flags");
   AST_SB_CZ: assert property (sb |=>
      flags.chained_zero_flag == ($past(d[7:0]) == 8'h00 && $past(flags.chained_zero_flag)))
      else $error("chained zero");
   cover property (sb && flags.carry_flag);
   cover property (ok && o == 3'h2);
   cover property (sb ##2 sb);
endmodule
bind rrso_top rrso_top_chk u_chk (.core_clk(core_clk), .rstn(rstn), .op_valid(op_valid), .op_req(op_req),
   .mem_we(mem_we), .mem_wdata(mem_wdata), .acc(acc), .flags(flags));
`default_nettype wire

/* File: tb/rrso_top_test.sv */
// rrso_top_test: directed scenarios for rrso_top
// assumes: rrso_pkg, rrso_top and the checker compiled first
`timescale 1ns/100ps
`default_nettype none
module rrso_top_test;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic op_valid = 1'b0;
   rrso_pkg::rrso_req_t op_req = 11'h000;
   logic acc_load = 1'b0;
   logic flags_load = 1'b0;
   logic [7:0] acc_load_data = 8'h00;
   rrso_pkg::rrso_flags_t flags_load_data = 6'h00;
   logic mem_we;
   logic [7:0] mem_wdata, acc;
   rrso_pkg::rrso_flags_t flags;
   int n_fail = 0;
   int samples_checked = 0;
   always #2 core_clk = ~core_clk;
   rrso_top dut (.core_clk(core_clk), .rstn(rstn), .op_valid(op_valid), .op_req(op_req), .acc_load(acc_load),
      .acc_load_data(acc_load_data), .flags_load(flags_load), .flags_load_data(flags_load_data),
      .mem_we(mem_we), .mem_wdata(mem_wdata), .acc(acc), .flags(flags));
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic ld(input logic [7:0] a, input logic [5:0] f);
      @(negedge core_clk);
      acc_load = 1'b1;
      flags_load = 1'b1;
      acc_load_data = a;
      flags_load_data = f;
      @(negedge core_clk);
      acc_load = 1'b0;
      flags_load = 1'b0;
   endtask
   // mem_wdata expected to hold the last written byte between pulses
   task automatic run(input logic [2:0] o, input logic [7:0] m, input logic we, input logic [7:0] d,
      input logic [7:0] a, input logic [5:0] f);
      @(negedge core_clk);
      op_valid = 1'b1;
      op_req = {o, m};
      @(negedge core_clk);
      op_valid = 1'b0;
      chk({7'h00, mem_we}, {7'h00, we});
      chk(mem_wdata, d);
      chk(acc, a);
      chk({2'h0, flags}, {2'h0, f});
   endtask
   task automatic t_rot();
      ld(8'h5a, 6'h3f);
      run(3'h0, 8'h81, 1'b1, 8'hc0, 8'h5a, 6'h3f);
      run(3'h1, 8'h02, 1'b0, 8'hc0, 8'h01, 6'h3f);
   endtask
   task automatic t_rrc();
      ld(8'h5a, 6'h04);
      run(3'h2, 8'h02, 1'b1, 8'h81, 8'h5a, 6'h00);
      run(3'h3, 8'h01, 1'b0, 8'h81, 8'h00, 6'h04);
   endtask
   task automatic t_sub();
      ld(8'h10, 6'h04);
      run(3'h4, 8'h20, 1'b0, 8'h81, 8'hf0, 6'h0a);
      run(3'h5, 8'hef, 1'b1, 8'h00, 8'hf0, 6'h14);
      ld(8'h80, 6'h04);
      run(3'h4, 8'h01, 1'b0, 8'h00, 8'h7f, 6'h26);
      ld(8'h33, 6'h05);
      run(3'h4, 8'h33, 1'b0, 8'h00, 8'h00, 6'h1d);
   endtask
   // a same-cycle load loses to the op; codes 6 and 7 change nothing
   task automatic t_misc();
      ld(8'h44, 6'h3f);
      acc_load_data = 8'h99;
      flags_load_data = 6'h00;
      @(negedge core_clk);
      acc_load = 1'b1;
      flags_load = 1'b1;
      op_valid = 1'b1;
      op_req = {3'h1, 8'h0c};
      @(negedge core_clk);
      acc_load = 1'b0;
      flags_load = 1'b0;
      op_valid = 1'b0;
      chk(acc, 8'h06);
      chk({2'h0, flags}, 8'h3f);
      run(3'h6, 8'h12, 1'b0, 8'h00, 8'h06, 6'h3f);
      run(3'h7, 8'h12, 1'b0, 8'h00, 8'h06, 6'h3f);
   endtask
   initial begin
      repeat (5) @(negedge core_clk);
      rstn = 1'b1;
      repeat (2) @(negedge core_clk);
      t_rot();
      t_rrc();
      t_sub();
      t_misc();
      finish_test();
   end
   initial begin
      #2000;
      n_fail++;
      finish_test();
   end
endmodule
`default_nettype wire
